// file: src/sbrw_pkg.sv
/*
  Shared constants and types for the burst read/write link: the memory-side
  end (device) and the controller-side end (host).
  Assumes both ends and the interface import this package.
*/
package sbrw_pkg;

  // --------------------------------------------------------------------
  // Command encoding on the link
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    SBRW_CMD_NOP = 3'h0,
    SBRW_CMD_ACT = 3'h1,
    SBRW_CMD_RD  = 3'h2,
    SBRW_CMD_WR  = 3'h3,
    SBRW_CMD_PRE = 3'h4,
    SBRW_CMD_MRS = 3'h5
  } sbrw_cmd_type;

  // --------------------------------------------------------------------
  // Mode register zero burst-length field
  // --------------------------------------------------------------------
  localparam logic [1:0] SBRW_BL_FIXED8 = 2'h0;
  localparam logic [1:0] SBRW_BL_OTF    = 2'h1;
  localparam logic [1:0] SBRW_BL_FIXED4 = 2'h2;
  localparam logic [1:0] SBRW_MR0_RST   = 2'h1;

  localparam int unsigned SBRW_BEATS_CHOP = 4;
  localparam int unsigned SBRW_BEATS_FULL = 8;
  localparam int unsigned SBRW_COL_SPACING = 4;

  // --------------------------------------------------------------------
  // Timing in link cycles (link period 64 ns unless host divides)
  // --------------------------------------------------------------------
  localparam int unsigned SBRW_LINK_NS        = 64;
  localparam int unsigned SBRW_RTP_NCK        = 4;
  localparam real         SBRW_RTP_NS         = 7.5;
  localparam int unsigned SBRW_RTP_NS_CYC     = int'($ceil(SBRW_RTP_NS / SBRW_LINK_NS));
  localparam int unsigned SBRW_RTP_CYC        =
    (SBRW_RTP_NCK > SBRW_RTP_NS_CYC) ? SBRW_RTP_NCK : SBRW_RTP_NS_CYC;
  localparam int unsigned SBRW_RAS_CYC        = 6;
  localparam int unsigned SBRW_RP_CYC         = 3;
  localparam int unsigned SBRW_RC_CYC         = 9;
  localparam logic [3:0]  SBRW_AL_RST         = 4'h0;
  localparam logic [3:0]  SBRW_CL_RST         = 4'h6;
  localparam int unsigned SBRW_CLK_DIV        = 8;
  localparam int unsigned SBRW_LOCK_CYC       = 16;

  // Controller register offsets (AXI4-Lite byte addresses)
  localparam logic [7:0] SBRW_REG_CMD    = 8'h00;
  localparam logic [7:0] SBRW_REG_ADDR   = 8'h04;
  localparam logic [7:0] SBRW_REG_WDATA  = 8'h08;
  localparam logic [7:0] SBRW_REG_RDATA  = 8'h0c;
  localparam logic [7:0] SBRW_REG_STATUS = 8'h10;

endpackage : sbrw_pkg

// file: src/sbrw_if.sv
/*
  Link between controller and memory end.
  Assumes the host drives the link clock; the interface resolves the data wire on d_dq_oe.
*/
`timescale 1ns/100ps
interface sbrw_if;
  import sbrw_pkg::*;
  logic         link_clk;
  logic         link_rstn;
  sbrw_cmd_type cmd;
  logic [2:0]   bank;
  logic [13:0]  addr;
  logic         bc_sel;
  logic         auto_pre;
  logic [7:0]   h_dq_o;
  logic         h_dq_oe;
  logic [7:0]   d_dq_o;
  logic         d_dq_oe;
  logic [7:0]   dq;

  assign dq = d_dq_oe ? d_dq_o : h_dq_o;

  modport host (output link_clk, link_rstn, cmd, bank, addr, bc_sel, auto_pre,
                output h_dq_o, h_dq_oe, input dq);
  modport dev  (input link_clk, link_rstn, cmd, bank, addr, bc_sel, auto_pre,
                output d_dq_o, d_dq_oe, input dq);
endinterface : sbrw_if

// file: src/sbrw_host.sv
/*
  Controller end: AXI4-Lite registers, link clock divider, command sequencer
  that enforces spacing rules.
  Assumes the memory end on the other side of sbrw_if.
*/
// Local design decisions: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
module sbrw_host
  import sbrw_pkg::*;
(
  // System
  input  wire logic        mclk_in,
  input  wire logic        rstn_in,
  // AXI4-Lite slave
  input  wire logic [7:0]  awaddr_in,
  input  wire logic        awvalid_in,
  output logic             awready_out,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wvalid_in,
  output logic             wready_out,
  output logic [1:0]       bresp_out,
  output logic             bvalid_out,
  input  wire logic        bready_in,
  input  wire logic [7:0]  araddr_in,
  input  wire logic        arvalid_in,
  output logic             arready_out,
  output logic [31:0]      rdata_out,
  output logic [1:0]       rresp_out,
  output logic             rvalid_out,
  input  wire logic        rready_in,
  // Link
  sbrw_if.host             lnk
);

  // ----------------------------------------------------------------------
  // Link clock divider (mclk domain)
  // ----------------------------------------------------------------------
  logic [2:0] div_r;
  logic       lclk_r;
  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      div_r  <= 3'h0;
      lclk_r <= 1'b0;
    end
    else
    begin
      div_r <= div_r + 3'h1;
      if (div_r == 3'h3 || div_r == 3'h7)
        lclk_r <= ~lclk_r;
    end
  end
  assign lnk.link_clk  = lclk_r;
  assign lnk.link_rstn = rstn_in;

  // ----------------------------------------------------------------------
  // AXI4-Lite registers (mclk domain)
  // ----------------------------------------------------------------------
  logic        aw_hold_r, w_hold_r;
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic [31:0] cmd_reg_r, addr_reg_r, wdat_reg_r;
  logic        go_tgl_r;
  logic        bvalid_r, rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r, bresp_r;
  logic [7:0]  rd_word_m;
  logic        busy_m;

  wire do_write = aw_hold_r && w_hold_r && !bvalid_r;
  wire do_read  = arvalid_in && !rvalid_r;
  wire wr_map   = (aw_addr_r == SBRW_REG_CMD) || (aw_addr_r == SBRW_REG_ADDR) ||
                  (aw_addr_r == SBRW_REG_WDATA);
  wire rd_map   = araddr_in <= SBRW_REG_STATUS && araddr_in[1:0] == 2'h0;
  wire [31:0] rd_mux =
    (araddr_in == SBRW_REG_CMD)    ? cmd_reg_r :
    (araddr_in == SBRW_REG_ADDR)   ? addr_reg_r :
    (araddr_in == SBRW_REG_WDATA)  ? wdat_reg_r :
    (araddr_in == SBRW_REG_RDATA)  ? {24'h0, rd_word_m} :
    (araddr_in == SBRW_REG_STATUS) ? {31'h0, busy_m} : 32'h0;

  assign awready_out = !aw_hold_r;
  assign wready_out  = !w_hold_r;
  assign arready_out = !rvalid_r;
  assign bvalid_out  = bvalid_r;
  assign bresp_out   = bresp_r;
  assign rvalid_out  = rvalid_r;
  assign rdata_out   = rdata_r;
  assign rresp_out   = rresp_r;

  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      aw_addr_r <= 8'h0;
      w_data_r  <= 32'h0;
      cmd_reg_r <= 32'h0;
      addr_reg_r <= 32'h0;
      wdat_reg_r <= 32'h0;
      go_tgl_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= 2'h0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0;
      rresp_r   <= 2'h0;
    end
    else
    begin
      if (awvalid_in && !aw_hold_r)
      begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= awaddr_in;
      end
      if (wvalid_in && !w_hold_r)
      begin
        w_hold_r <= 1'b1;
        w_data_r <= wdata_in;
      end
      if (do_write)
      begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_map ? 2'h0 : 2'h2;
        if (aw_addr_r == SBRW_REG_ADDR)
          addr_reg_r <= w_data_r;
        if (aw_addr_r == SBRW_REG_WDATA)
          wdat_reg_r <= w_data_r;
        // Command write launches one link operation; ignored while busy
        if (aw_addr_r == SBRW_REG_CMD && !busy_m)
        begin
          cmd_reg_r <= w_data_r;
          go_tgl_r  <= ~go_tgl_r;
        end
      end
      else if (bvalid_r && bready_in)
        bvalid_r <= 1'b0;
      if (do_read)
      begin
        rvalid_r <= 1'b1;
        rdata_r  <= rd_mux;
        rresp_r  <= rd_map ? 2'h0 : 2'h2;
      end
      else if (rvalid_r && rready_in)
        rvalid_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Link sequencer (link clock domain)
  // ----------------------------------------------------------------------
  typedef enum {SQ_IDLE, SQ_WAIT, SQ_WBURST, SQ_RBURST} sbrw_sq_type;
  sbrw_sq_type sq_r;
  logic [2:0]  go_sync_r;
  logic        busy_l_r;
  logic [7:0]  rd_word_l_r;
  logic [7:0]  gap_r, ras_r, rp_r, rc_r, pre_r;
  logic [3:0]  beat_r, beats_r;
  logic [3:0]  rl_r;
  logic [1:0]  mode_l_r;
  wire [2:0]  op   = cmd_reg_r[2:0];
  wire        bc_q = cmd_reg_r[8];
  wire        ap_q = cmd_reg_r[9];
  wire [3:0]  al_q = cmd_reg_r[19:16];
  wire [3:0]  cl_q = cmd_reg_r[23:20];
  wire        go_l = go_sync_r[2] ^ go_sync_r[1];
  // Host mirrors the burst mode it last programmed
  wire h_full8 = mode_l_r == SBRW_BL_FIXED8 ||
                 (mode_l_r == SBRW_BL_OTF && bc_q);
  wire col_ok = gap_r == 8'h0;
  wire pre_ok = pre_r == 8'h0 && ras_r == 8'h0;
  wire act_ok = rp_r == 8'h0 && rc_r == 8'h0;
  wire op_ok  = (op == 3'h1) ? act_ok :
                (op == 3'h4) ? pre_ok :
                (op == 3'h2 || op == 3'h3) ? col_ok : 1'b1;

  always_ff @(posedge lclk_r or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      go_sync_r <= 3'h0;
      sq_r      <= SQ_IDLE;
      busy_l_r  <= 1'b0;
      rd_word_l_r <= 8'h0;
      gap_r <= 8'h0;
      ras_r <= 8'h0;
      rp_r  <= 8'h0;
      rc_r  <= 8'h0;
      pre_r <= 8'h0;
      beat_r <= 4'h0;
      beats_r <= 4'h0;
      rl_r  <= 4'h0;
      mode_l_r <= SBRW_MR0_RST;
      lnk.cmd <= SBRW_CMD_NOP;
      lnk.bank <= 3'h0;
      lnk.addr <= 14'h0;
      lnk.bc_sel <= 1'b0;
      lnk.auto_pre <= 1'b0;
      lnk.h_dq_o <= 8'h0;
      lnk.h_dq_oe <= 1'b0;
    end
    else
    begin
      go_sync_r <= {go_sync_r[1:0], go_tgl_r};
      lnk.cmd <= SBRW_CMD_NOP;
      if (gap_r != 8'h0) gap_r <= gap_r - 8'h1;
      if (ras_r != 8'h0) ras_r <= ras_r - 8'h1;
      if (rp_r  != 8'h0) rp_r  <= rp_r  - 8'h1;
      if (rc_r  != 8'h0) rc_r  <= rc_r  - 8'h1;
      if (pre_r != 8'h0) pre_r <= pre_r - 8'h1;
      unique case (sq_r)
        SQ_IDLE:
          if (go_l)
          begin
            busy_l_r <= 1'b1;
            sq_r     <= SQ_WAIT;
          end
        SQ_WAIT:
          if (op_ok)
          begin
            lnk.cmd      <= sbrw_cmd_type'(op);
            lnk.bank     <= addr_reg_r[26:24];
            lnk.addr     <= addr_reg_r[13:0];
            lnk.bc_sel   <= bc_q;
            lnk.auto_pre <= ap_q;
            beat_r       <= 4'h0;
            beats_r      <= h_full8 ? 4'h8 : 4'h4;
            if (op == 3'h5)
              mode_l_r <= addr_reg_r[1:0];
            rl_r         <= al_q + cl_q;
            sq_r         <= SQ_IDLE;
            busy_l_r     <= 1'b0;
            if (op == 3'h1)
            begin
              ras_r <= 8'(SBRW_RAS_CYC);
              rc_r  <= 8'(SBRW_RC_CYC);
            end
            if (op == 3'h4)
              rp_r <= 8'(SBRW_RP_CYC);
            if (op == 3'h2 || op == 3'h3)
              gap_r <= 8'(SBRW_COL_SPACING);
            if (op == 3'h2)
            begin
              pre_r    <= 8'(al_q) + 8'(SBRW_RTP_CYC);
              sq_r     <= SQ_RBURST;
              busy_l_r <= 1'b1;
            end
            if (op == 3'h3)
            begin
              sq_r     <= SQ_WBURST;
              busy_l_r <= 1'b1;
            end
          end
        SQ_WBURST:
        begin
          // Clean beats on every edge keep the write valid
          lnk.h_dq_oe <= 1'b1;
          lnk.h_dq_o  <= wdat_reg_r[7:0] + 8'(beat_r);
          beat_r      <= beat_r + 4'h1;
          if (beat_r == beats_r)
          begin
            lnk.h_dq_oe <= 1'b0;
            sq_r        <= SQ_IDLE;
            busy_l_r    <= 1'b0;
          end
        end
        SQ_RBURST:
        begin
          // First beat seen once latency has elapsed
          if (rl_r != 4'h0)
            rl_r <= rl_r - 4'h1;
          else
          begin
            if (beat_r == 4'h0)
              rd_word_l_r <= lnk.dq;
            beat_r <= beat_r + 4'h1;
            if (beat_r == beats_r - 4'h1)
            begin
              sq_r     <= SQ_IDLE;
              busy_l_r <= 1'b0;
            end
          end
        end
      endcase
    end
  end

  // Status back into mclk domain; read word is stable once busy drops
  logic [1:0] busy_sync_r;
  logic [7:0] rd_word_r;
  logic       pend_r;
  // Pending covers the gap before the link side's busy is seen here
  wire        go_launch = do_write && aw_addr_r == SBRW_REG_CMD && !busy_m;
  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      busy_sync_r <= 2'h0;
      rd_word_r   <= 8'h0;
      pend_r      <= 1'b0;
    end
    else
    begin
      busy_sync_r <= {busy_sync_r[0], busy_l_r};
      if (go_launch)
        pend_r <= 1'b1;
      else if (busy_sync_r[1])
        pend_r <= 1'b0;
      if (!busy_sync_r[1])
        rd_word_r <= rd_word_l_r;
    end
  end
  assign busy_m    = busy_sync_r[1] || pend_r;
  assign rd_word_m = rd_word_r;

endmodule // sbrw_host

// file: src/sbrw_dev.sv
/*
  Memory end: decodes link commands, small array, read latency and burst length.
  Assumes the host keeps all command spacing rules.
*/
`timescale 1ns/100ps
module sbrw_dev
  import sbrw_pkg::*;
#(
  parameter int unsigned DEPTH = 16
)
(
  // Link
  sbrw_if.dev              lnk,
  // Status
  input  wire logic        dll_lock_in,
  output logic             row_open_out
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [7:0] mem_r [DEPTH];
  logic [1:0] bl_mode_r;
  logic [3:0] al_r, cl_r;
  logic [1:0] lock_sync_r;
  logic [3:0] cnt_r, beats_r, beat_r;
  logic       rd_act_r, wr_act_r, open_r;
  logic [$clog2(DEPTH)-1:0] col_r;

  // Column taken from low bits only; chop select is a separate port
  wire [$clog2(DEPTH)-1:0] col_w = lnk.addr[$clog2(DEPTH)-1:0];
  wire full8 = bl_mode_r == SBRW_BL_FIXED8 ||
               (bl_mode_r == SBRW_BL_OTF && lnk.bc_sel);
  wire col_cmd = lnk.cmd == SBRW_CMD_RD || lnk.cmd == SBRW_CMD_WR;

  assign row_open_out = open_r;

  always_ff @(posedge lnk.link_clk or negedge lnk.link_rstn)
  begin
    if (!lnk.link_rstn)
    begin
      bl_mode_r <= SBRW_MR0_RST;
      al_r <= SBRW_AL_RST;
      cl_r <= SBRW_CL_RST;
      lock_sync_r <= 2'h0;
      cnt_r <= 4'h0;
      beats_r <= 4'h0;
      beat_r <= 4'h0;
      rd_act_r <= 1'b0;
      wr_act_r <= 1'b0;
      open_r <= 1'b0;
      col_r <= '0;
      lnk.d_dq_o <= 8'h0;
      lnk.d_dq_oe <= 1'b0;
    end
    else
    begin
      lock_sync_r <= {lock_sync_r[0], dll_lock_in};
      unique case (lnk.cmd)
        SBRW_CMD_MRS:
        begin
          bl_mode_r <= lnk.addr[1:0];
          al_r <= lnk.addr[7:4];
          cl_r <= lnk.addr[11:8];
        end
        SBRW_CMD_ACT: open_r <= 1'b1;
        SBRW_CMD_PRE: open_r <= 1'b0;
        default: ;
      endcase
      if (col_cmd)
      begin
        col_r    <= col_w;
        beats_r  <= full8 ? 4'h8 : 4'h4;
        beat_r   <= 4'h0;
        // Launch one cycle early so the first beat is on the wire at the latency edge
        cnt_r    <= al_r + cl_r - 4'h2;
        rd_act_r <= lnk.cmd == SBRW_CMD_RD;
        wr_act_r <= lnk.cmd == SBRW_CMD_WR;
        if (lnk.auto_pre)
          open_r <= 1'b0;
      end
      else if (wr_act_r)
      begin
        // Bad beats only land in this burst's cells; no state can stick
        mem_r[col_r + beat_r[$clog2(DEPTH)-1:0]] <= lnk.dq;
        beat_r <= beat_r + 4'h1;
        if (beat_r == beats_r - 4'h1)
          wr_act_r <= 1'b0;
      end
      else if (rd_act_r)
      begin
        if (cnt_r != 4'h0)
          cnt_r <= cnt_r - 4'h1;
        else
        begin
          // Drive only when lock seen; output timing undefined otherwise
          lnk.d_dq_oe <= lock_sync_r[1];
          lnk.d_dq_o  <= mem_r[col_r + beat_r[$clog2(DEPTH)-1:0]];
          beat_r <= beat_r + 4'h1;
          if (beat_r == beats_r)
          begin
            lnk.d_dq_oe <= 1'b0;
            rd_act_r <= 1'b0;
          end
        end
      end
    end
  end

endmodule // sbrw_dev

// file: bench/sbrw_chk.sv
/*
  Checker for the burst link: command spacing and burst lengths.
  Assumes it watches the link beside sbrw_if, in the link clock domain.
*/
`timescale 1ns/100ps
module sbrw_chk
  import sbrw_pkg::*;
(
  // Link
  input wire logic         link_clk,
  input wire logic         link_rstn,
  input wire sbrw_cmd_type cmd,
  input wire logic [13:0]  addr,
  input wire logic         bc_sel,
  input wire logic         h_dq_oe,
  input wire logic         d_dq_oe
);
  logic [1:0] mode_r;
  wire logic  col_w   = (cmd == SBRW_CMD_RD) || (cmd == SBRW_CMD_WR);
  wire logic  short_w = (mode_r == SBRW_BL_FIXED4) || ((mode_r == SBRW_BL_OTF) && !bc_sel);

  // Mirrors the burst mode so length checks follow mode changes
  always_ff @(posedge link_clk or negedge link_rstn)
    if (!link_rstn)
      mode_r <= SBRW_MR0_RST;
    else if (cmd == SBRW_CMD_MRS)
      mode_r <= addr[1:0];

  default clocking @(posedge link_clk); endclocking
  default disable iff (!link_rstn);

  sequence s_rd4; d_dq_oe [*4]; endsequence
  sequence s_rd8; d_dq_oe [*8]; endsequence
  sequence s_wr4; h_dq_oe [*4]; endsequence
  sequence s_wr8; h_dq_oe [*8]; endsequence

  a_col_spacing: assert property (col_w |=> !col_w [*3])
    else $error("column commands too close");
  a_rd_to_pre: assert property ((cmd == SBRW_CMD_RD) |=> (cmd != SBRW_CMD_PRE) [*3])
    else $error("precharge too soon after read");
  a_act_to_pre: assert property ((cmd == SBRW_CMD_ACT) |=> (cmd != SBRW_CMD_PRE) [*5])
    else $error("precharge before row open time");
  a_pre_to_act: assert property ((cmd == SBRW_CMD_PRE) |=> (cmd != SBRW_CMD_ACT) [*2])
    else $error("activate before close period");
  a_row_cycle: assert property ((cmd == SBRW_CMD_ACT) |=> (cmd != SBRW_CMD_ACT) [*8])
    else $error("activate before row cycle time");
  a_rd_quiet: assert property ((cmd == SBRW_CMD_RD) |=> !d_dq_oe [*5])
    else $error("read data too early");
  a_rd_chop: assert property ((cmd == SBRW_CMD_RD) && short_w |-> ##6 s_rd4)
    else $error("short read burst wrong");
  a_rd_full: assert property ((cmd == SBRW_CMD_RD) && !short_w |-> ##6 s_rd8)
    else $error("full read burst wrong");
  a_wr_chop: assert property ((cmd == SBRW_CMD_WR) && short_w |-> ##1 s_wr4)
    else $error("short write burst wrong");
  a_wr_full: assert property ((cmd == SBRW_CMD_WR) && !short_w |-> ##1 s_wr8)
    else $error("full write burst wrong");
endmodule // sbrw_chk

// file: bench/tb.sv
/*
  Testbench: both link ends joined, host driven over AXI4-Lite.
  Assumes the host divides the link clock from mclk_in.
*/
`timescale 1ns/100ps
module tb;
  import sbrw_pkg::*;
  logic        mclk_in, rstn_in, dll_lock, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr, base;
  logic [31:0] wdata, rd_v;
  logic [2:0]  bank;
  logic [65:0] re;
  wire logic   awready, wready, bvalid, arready, rvalid, row_open;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  logic [1:0]  bq[$];
  logic [65:0] rq[$];
  logic [1:0]  modes[3] = '{SBRW_BL_FIXED8, SBRW_BL_OTF, SBRW_BL_FIXED4};
  int          n_mismatch, n_checks, cyc;

  sbrw_if lnk();
  sbrw_host u_sbrw_host(.mclk_in(mclk_in), .rstn_in(rstn_in), .awaddr_in(awaddr),
    .awvalid_in(awvalid), .awready_out(awready), .wdata_in(wdata), .wvalid_in(wvalid),
    .wready_out(wready), .bresp_out(bresp), .bvalid_out(bvalid), .bready_in(bready),
    .araddr_in(araddr), .arvalid_in(arvalid), .arready_out(arready), .rdata_out(rdata),
    .rresp_out(rresp), .rvalid_out(rvalid), .rready_in(rready), .lnk(lnk));
  sbrw_dev #(.DEPTH(16)) u_sbrw_dev(.lnk(lnk), .dll_lock_in(dll_lock), .row_open_out(row_open));
  sbrw_chk u_sbrw_chk(.link_clk(lnk.link_clk), .link_rstn(lnk.link_rstn), .cmd(lnk.cmd),
    .addr(lnk.addr), .bc_sel(lnk.bc_sel), .h_dq_oe(lnk.h_dq_oe), .d_dq_oe(lnk.d_dq_oe));

  initial
  begin
    mclk_in = 1'b0;
    forever #2 mclk_in = ~mclk_in;
  end

  // --------------------------------------------------------------------
  // Reporting
  // --------------------------------------------------------------------
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("mismatches %0d checks %0d", n_mismatch, n_checks);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Whole run needs some 2.5k cycles
  always @(posedge mclk_in)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      n_mismatch++;
      finish_test;
    end
  end

  // Response watcher takes the oldest noted expectation
  always @(posedge mclk_in)
  begin
    if (bvalid && bready && bq.size() > 0)
      check({32'h0, bresp}, {32'h0, bq.pop_front()});
    if (rvalid && rready && rq.size() > 0)
    begin
      re = rq.pop_front();
      check({rresp, rdata & re[63:32]}, {re[65:64], re[31:0]});
    end
  end

  // --------------------------------------------------------------------
  // Bus and link tasks
  // --------------------------------------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad;
    logic wd;
    bq.push_back(er);
    @(posedge mclk_in);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    ad = 1'b0;
    wd = 1'b0;
    while (!(ad && wd))
    begin
      @(posedge mclk_in);
      if (!ad && awready)
      begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready)
      begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge mclk_in); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                        input logic [1:0] er);
    rq.push_back({er, m, e});
    @(posedge mclk_in);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge mclk_in); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge mclk_in);
    rd_v = rdata;
    rready <= 1'b0;
  endtask

  task automatic do_cmd(input sbrw_cmd_type op, input logic bc, input logic ap);
    axi_wr(SBRW_REG_CMD, {8'h00, 4'h6, 4'h0, 6'h00, ap, bc, 5'h00, op}, 2'h0);
    do axi_rd(SBRW_REG_STATUS, 32'h0, 32'h0, 2'h0); while (rd_v[0] !== 1'b0);
  endtask

  // Counts beats on the wire mid-cycle, away from the launching edge
  task automatic burst(input logic dv, input int n, input logic [7:0] b);
    int k;
    k = 0;
    forever
    begin
      @(negedge lnk.link_clk);
      if ((dv ? lnk.d_dq_oe : lnk.h_dq_oe) === 1'b1)
      begin
        check({26'h0, lnk.dq}, {26'h0, b + 8'(k)});
        k++;
      end
      else if (k > 0)
        break;
    end
    check(34'(k), 34'(n));
  endtask

  task automatic run_pair(input logic [1:0] m, input logic bc);
    logic       ap;
    logic [3:0] col;
    int         n;
    ap   = 1'($urandom);
    base = 8'($urandom);
    col  = {1'($urandom), 3'h0};
    n    = (m == SBRW_BL_FIXED4 || (m == SBRW_BL_OTF && !bc)) ? 4 : 8;
    axi_wr(SBRW_REG_ADDR, {5'h0, bank, 10'h0, 14'($urandom)}, 2'h0);
    do_cmd(SBRW_CMD_ACT, 1'b0, 1'b0);
    axi_wr(SBRW_REG_ADDR, {5'h0, bank, 20'h0, col}, 2'h0);
    axi_wr(SBRW_REG_WDATA, {24'h0, base}, 2'h0);
    fork
      do_cmd(SBRW_CMD_WR, bc, 1'b0);
      burst(1'b0, n, base);
    join
    fork
      do_cmd(SBRW_CMD_RD, bc, ap);
      burst(1'b1, n, base);
    join
    axi_rd(SBRW_REG_RDATA, 32'hff, {24'h0, base}, 2'h0);
    repeat (2) @(negedge lnk.link_clk);
    check({33'h0, row_open}, {33'h0, !ap});
    do_cmd(SBRW_CMD_PRE, 1'b0, 1'b0);
    repeat (2) @(negedge lnk.link_clk);
    check({33'h0, row_open}, 34'h0);
  endtask

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial
  begin
    rstn_in = 1'b0;
    dll_lock = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = 48'h0;
    n_mismatch = 0;
    n_checks = 0;
    cyc = 0;
    void'($urandom(32338));
    // Two link clocks of reset need sixteen system clocks
    repeat (16) @(posedge mclk_in);
    rstn_in <= 1'b1;
    axi_rd(SBRW_REG_STATUS, 32'hffffffff, 32'h0, 2'h0);
    axi_rd(8'h20, 32'h0, 32'h0, 2'h2);
    axi_wr(8'h24, 32'h0, 2'h2);
    bank = 3'($urandom);
    for (int mi = 0; mi < 3; mi++)
    begin
      axi_wr(SBRW_REG_ADDR, {20'h0, 4'h6, 4'h0, 2'h0, modes[mi]}, 2'h0);
      do_cmd(SBRW_CMD_MRS, 1'b0, 1'b0);
      for (int bc = 0; bc < 2; bc++)
        run_pair(modes[mi], 1'(bc));
    end
    // Mid-run reset must close the open row and clear status
    do_cmd(SBRW_CMD_ACT, 1'b0, 1'b0);
    repeat (2) @(negedge lnk.link_clk);
    check({33'h0, row_open}, 34'h1);
    @(posedge mclk_in);
    rstn_in <= 1'b0;
    repeat (16) @(posedge mclk_in);
    rstn_in <= 1'b1;
    check({33'h0, row_open}, 34'h0);
    axi_rd(SBRW_REG_STATUS, 32'hffffffff, 32'h0, 2'h0);
    finish_test;
  end
endmodule // tb
